/* File: include/psr_pkg.sv */
package psr_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ZERO_DELAY_CONTROL_ADDR = 10'h01E;
  localparam logic [ADDR_W-1:0] PLL_STATUS_READBACK_ADDR = 10'h01F;
  localparam logic [DATA_W-1:0] ZERO_DELAY_CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ZD_ENABLE_BIT = 1;
  localparam int ZD_EXTERNAL_BIT = 2;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_FIRST_REF_ABOVE_BIT = 1;
  localparam int ST_SECOND_REF_ABOVE_BIT = 2;
  localparam int ST_OSC_ABOVE_BIT = 3;
  localparam int ST_SECOND_REF_SEL_BIT = 4;
  localparam int ST_HOLDOVER_BIT = 5;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } psr_req_t;

  typedef struct packed {
    logic holdover_active;
    logic second_reference_input_selected;
    logic tuned_oscillator_above;
    logic second_reference_input_above;
    logic first_reference_input_above;
    logic digital_lock;
  } psr_status_t;

endpackage : psr_pkg

/* File: verilog/psr_status_sampler.sv */
`timescale 1ns/1ns
module psr_status_sampler (
  input wire logic sys_clk,
  input wire logic rst,
  input wire psr_pkg::psr_status_t status_in,
  output psr_pkg::psr_status_t status_q
);

  typedef struct packed {
    psr_pkg::psr_status_t snap;
  } psr_sampler_state_t;

  psr_sampler_state_t state;
  psr_sampler_state_t next_state;

  // ----------------------------------------
  // live snapshot, one register stage
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.snap = status_in;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign status_q = state.snap;

endmodule : psr_status_sampler

/* File: verilog/psr_pll_status_readback.sv */
`timescale 1ns/1ns
module psr_pll_status_readback (
  input wire logic sys_clk,
  input wire logic rst,
  input wire psr_pkg::psr_req_t req,
  output logic [psr_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  input wire psr_pkg::psr_status_t status_in,
  output logic zero_delay_enable,
  output logic zero_delay_internal,
  output logic zero_delay_external
);

  typedef struct packed {
    logic [psr_pkg::DATA_W-1:0] zd_ctrl;
    logic [psr_pkg::DATA_W-1:0] rd_data;
    logic rd_valid;
  } psr_state_t;

  psr_state_t state;
  psr_state_t next_state;
  psr_pkg::psr_status_t status_q;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [psr_pkg::DATA_W-1:0] psr_pack_status(
    input psr_pkg::psr_status_t s
  );
    logic [psr_pkg::DATA_W-1:0] w;
    w = '0;
    w[psr_pkg::ST_HOLDOVER_BIT] = s.holdover_active;
    w[psr_pkg::ST_SECOND_REF_SEL_BIT] = s.second_reference_input_selected;
    w[psr_pkg::ST_OSC_ABOVE_BIT] = s.tuned_oscillator_above;
    w[psr_pkg::ST_SECOND_REF_ABOVE_BIT] = s.second_reference_input_above;
    w[psr_pkg::ST_FIRST_REF_ABOVE_BIT] = s.first_reference_input_above;
    w[psr_pkg::ST_LOCK_BIT] = s.digital_lock;
    return w;
  endfunction : psr_pack_status

  function automatic logic psr_hit(
    input psr_pkg::psr_req_t r,
    input logic [psr_pkg::ADDR_W-1:0] a
  );
    return r.valid && (r.addr == a);
  endfunction : psr_hit

  // ----------------------------------------
  // status snapshot
  // ----------------------------------------
  // registered so a read never sees a mid-cycle change of the monitors
  psr_status_sampler psr_status_sampler_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .status_in(status_in),
    .status_q(status_q)
  );

  // ----------------------------------------
  // register access
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.rd_valid = 1'b0;
    if (psr_hit(req, psr_pkg::ZERO_DELAY_CONTROL_ADDR) && req.write) begin
      next_state.zd_ctrl = req.wdata;
    end
    // status writes fall through: no storage behind that address
    if (req.valid && !req.write) begin
      next_state.rd_valid = 1'b1;
      if (psr_hit(req, psr_pkg::ZERO_DELAY_CONTROL_ADDR)) begin
        next_state.rd_data = state.zd_ctrl;
      end else if (psr_hit(req, psr_pkg::PLL_STATUS_READBACK_ADDR)) begin
        next_state.rd_data = psr_pack_status(status_q);
      end else begin
        next_state.rd_data = psr_pkg::UNMAPPED_READ_VALUE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state.zd_ctrl <= psr_pkg::ZERO_DELAY_CONTROL_RESET;
      state.rd_data <= '0;
      state.rd_valid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rd_data = state.rd_data;
  assign rd_valid = state.rd_valid;
  assign zero_delay_enable = state.zd_ctrl[psr_pkg::ZD_ENABLE_BIT];
  // mode bit only matters while the function is on
  assign zero_delay_internal = state.zd_ctrl[psr_pkg::ZD_ENABLE_BIT] &&
                               !state.zd_ctrl[psr_pkg::ZD_EXTERNAL_BIT];
  assign zero_delay_external = state.zd_ctrl[psr_pkg::ZD_ENABLE_BIT] &&
                               state.zd_ctrl[psr_pkg::ZD_EXTERNAL_BIT];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_status_read;
    req.valid && !req.write && (req.addr == psr_pkg::PLL_STATUS_READBACK_ADDR);
  endsequence

  sequence s_ctrl_write;
    req.valid && req.write && (req.addr == psr_pkg::ZERO_DELAY_CONTROL_ADDR);
  endsequence

  sequence s_any_read;
    req.valid && !req.write;
  endsequence

  sequence s_ctrl_read;
    req.valid && !req.write && (req.addr == psr_pkg::ZERO_DELAY_CONTROL_ADDR);
  endsequence

  sequence s_unmapped_read;
    req.valid && !req.write &&
    (req.addr != psr_pkg::ZERO_DELAY_CONTROL_ADDR) &&
    (req.addr != psr_pkg::PLL_STATUS_READBACK_ADDR);
  endsequence

  // write, one idle edge, then read back: the spacing of single accesses
  sequence s_write_idle_read;
    s_ctrl_write ##1 !req.valid ##1 s_ctrl_read;
  endsequence

  AST_ZD_ENABLE: assert property (s_ctrl_write |=>
    zero_delay_enable == $past(req.wdata[psr_pkg::ZD_ENABLE_BIT]))
    else $error("zero delay enable does not follow written bit");

  AST_ZD_MODE: assert property (s_ctrl_write |=>
    (zero_delay_external == ($past(req.wdata[psr_pkg::ZD_ENABLE_BIT]) &&
                             $past(req.wdata[psr_pkg::ZD_EXTERNAL_BIT]))) &&
    !(zero_delay_external && zero_delay_internal))
    else $error("zero delay mode wrong");

  AST_HOLDOVER: assert property (s_status_read |=> rd_valid &&
    rd_data[psr_pkg::ST_HOLDOVER_BIT] == $past(status_in.holdover_active, 2))
    else $error("holdover bit wrong");

  AST_REF_SEL: assert property (s_status_read |=>
    rd_data[psr_pkg::ST_SECOND_REF_SEL_BIT] ==
      $past(status_in.second_reference_input_selected, 2))
    else $error("reference select bit wrong");

  AST_OSC_ABOVE: assert property (s_status_read |=>
    rd_data[psr_pkg::ST_OSC_ABOVE_BIT] == $past(status_in.tuned_oscillator_above, 2))
    else $error("oscillator threshold bit wrong");

  AST_SECOND_REF_ABOVE: assert property (s_status_read |=>
    rd_data[psr_pkg::ST_SECOND_REF_ABOVE_BIT] ==
      $past(status_in.second_reference_input_above, 2))
    else $error("second reference threshold bit wrong");

  AST_FIRST_REF_ABOVE: assert property (s_status_read |=>
    rd_data[psr_pkg::ST_FIRST_REF_ABOVE_BIT] ==
      $past(status_in.first_reference_input_above, 2))
    else $error("first reference threshold bit wrong");

  AST_LOCK: assert property (s_status_read |=>
    rd_data[psr_pkg::ST_LOCK_BIT] == $past(status_in.digital_lock, 2) &&
    rd_data[7:6] == 2'h0)
    else $error("lock bit wrong");

  AST_STATUS_WRITE_IGNORED: assert property (
    (req.valid && req.write && (req.addr == psr_pkg::PLL_STATUS_READBACK_ADDR))
    |=> $stable(zero_delay_enable) && $stable(zero_delay_external) && !rd_valid)
    else $error("status write had an effect");

  AST_ZD_INTERNAL: assert property (s_ctrl_write |=>
    zero_delay_internal == ($past(req.wdata[psr_pkg::ZD_ENABLE_BIT]) &&
                            !$past(req.wdata[psr_pkg::ZD_EXTERNAL_BIT])))
    else $error("zero delay internal mode wrong");

  AST_CTRL_HOLD: assert property (
    !(req.valid && req.write && (req.addr == psr_pkg::ZERO_DELAY_CONTROL_ADDR))
    |=> $stable(zero_delay_enable) && $stable(zero_delay_internal) &&
        $stable(zero_delay_external))
    else $error("zero delay outputs changed without a control write");

  AST_CTRL_READBACK: assert property (s_write_idle_read |=>
    rd_valid && rd_data == $past(req.wdata, 3))
    else $error("control readback differs from written value");

  AST_STATUS_WRITE_KEEPS_DATA: assert property (
    (req.valid && req.write && (req.addr == psr_pkg::PLL_STATUS_READBACK_ADDR))
    |=> $stable(rd_data))
    else $error("status write disturbed read data");

  // ----------------------------------------
  // read answer checks
  // ----------------------------------------
  AST_READ_ANSWER: assert property (s_any_read |=> rd_valid)
    else $error("read got no answer");

  AST_NO_STRAY_VALID: assert property (!(req.valid && !req.write) |=> !rd_valid)
    else $error("read valid without a read");

  AST_RD_DATA_HOLD: assert property (!(req.valid && !req.write) |=> $stable(rd_data))
    else $error("read data changed without a read");

  // unmapped reads still answer, so software never waits on a hole
  AST_UNMAPPED_READ: assert property (s_unmapped_read |=>
    rd_valid && rd_data == psr_pkg::UNMAPPED_READ_VALUE)
    else $error("unmapped read returned wrong data");

endmodule : psr_pll_status_readback

/* File: verification/psr_pll_status_readback_tb_top.sv */
`timescale 1ns/1ns
module psr_pll_status_readback_tb_top;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  logic sys_clk;
  logic rst;
  psr_pkg::psr_req_t req;
  psr_pkg::psr_status_t status_in;
  logic [7:0] rd_data;
  logic rd_valid;
  logic zero_delay_enable;
  logic zero_delay_internal;
  logic zero_delay_external;
  logic [7:0] d;
  logic [7:0] v;
  int err_count;
  int checks_done;
  localparam logic [9:0] CTRL = psr_pkg::ZERO_DELAY_CONTROL_ADDR;
  localparam logic [9:0] STAT = psr_pkg::PLL_STATUS_READBACK_ADDR;

  psr_pll_status_readback psr_pll_status_readback_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .req(req),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .status_in(status_in),
    .zero_delay_enable(zero_delay_enable),
    .zero_delay_internal(zero_delay_internal),
    .zero_delay_external(zero_delay_external)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task give_verdict;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task wr(input logic [9:0] a, input logic [7:0] w);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b1, a, w};
    @(posedge sys_clk);
    req.valid <= 1'b0;
  endtask : wr

  // bounded wait: a lost answer must end the run, not hang it
  task rd(input logic [9:0] a, output logic [7:0] q);
    int i;
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      if (rd_valid === 1'b1) break;
    end
    q = rd_data;
    if (i == 4) begin
      err_count++;
      $display("Error rd_valid expected 1 seen 0");
      give_verdict();
    end
  endtask : rd

  task outs(input logic [7:0] c);
    @(negedge sys_clk);
    check("zero delay outs", {5'h00, zero_delay_enable, zero_delay_internal,
      zero_delay_external}, {5'h00, c[1], c[1] & ~c[2], c[1] & c[2]});
  endtask : outs

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    status_in = '0;
    err_count = 0;
    checks_done = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(CTRL, d);
    check("control reset", d, psr_pkg::ZERO_DELAY_CONTROL_RESET);
    outs(8'h00);
    // external select without enable must leave both modes off
    for (int k = 0; k < 5; k++) begin
      v = (k == 0) ? 8'h02 : (k == 1) ? 8'h06 : (k == 2) ? 8'h04 : (k == 3) ? 8'hA6 : 8'h00;
      wr(CTRL, v);
      outs(v);
      rd(CTRL, d);
      check("control readback", d, v);
    end
    for (int k = 0; k < 7; k++) begin
      @(posedge sys_clk);
      status_in <= psr_pkg::psr_status_t'(6'h01 << k);
      repeat (2) @(posedge sys_clk);
      rd(STAT, d);
      check("status bit", d, {2'b00, 6'h01 << k});
    end
    @(posedge sys_clk);
    status_in <= psr_pkg::psr_status_t'(6'h2A);
    wr(STAT, 8'hFF);
    rd(STAT, d);
    check("status after write", d, 8'h2A);
    rd(CTRL, d);
    check("control after status write", d, 8'h00);
    @(posedge sys_clk);
    status_in <= psr_pkg::psr_status_t'(6'h15);
    repeat (2) @(posedge sys_clk);
    rd(STAT, d);
    check("status live", d, 8'h15);
    wr(10'h100, 8'hFF);
    rd(10'h100, d);
    check("unmapped read", d, psr_pkg::UNMAPPED_READ_VALUE);
    rd(CTRL, d);
    check("control after unmapped write", d, 8'h00);
    wr(CTRL, 8'h06);
    outs(8'h06);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    outs(8'h00);
    give_verdict();
  end
endmodule : psr_pll_status_readback_tb_top
